// ===== dual_encoder_tx_sequencing.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "tx_seq_defs.svh"

module dual_encoder_tx_sequencing #(
  parameter int FIX_CLA_CYC = `FIX_CLA_CYC,
  parameter int FIX_ADV_CYC = `FIX_ADV_CYC,
  parameter int LED_PERIOD  = `LED_PERIOD_CYC,
  parameter int LED_NORM    = `LED_ON_NORM,
  parameter int LED_LOWBAT  = `LED_ON_LOWBAT
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // apb
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // buttons and battery
  input  wire logic [3:0]         buttons,
  input  wire logic               lowBattery,
  // transmitter control
  output logic                    txActive,
  output logic                    carrierOn,
  output logic                    encoderSel,
  output logic                    seedWord,
  output logic [3:0]              functionCode,
  output logic [1:0]              wordPhase,
  output logic [23:0]             carrier_frequency_word,
  output tx_seq_pkg::rf_setting_t rfSetting,
  output logic                    ledOut_n
);
  import tx_seq_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // indicator on-time must leave an off phase, guard must be non-empty
  if (LED_NORM >= LED_PERIOD || LED_LOWBAT >= LED_PERIOD || LED_NORM < 1
      || LED_LOWBAT < 1 || FIX_CLA_CYC < 1 || FIX_ADV_CYC < 1) begin : g_bad_timing
    $error("dual_encoder_tx_sequencing: bad timing parameters");
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  assignLo_q, assignHi_q, seedLo_q, seedHi_q;
  logic [23:0] carrier_q;
  logic [21:0] encCfg_q [2];
  logic [15:0] teCyc_q [2];
  logic [15:0] cntCfg_q [2];

  // writes land only at the edge that also shows pready to the master
  wire         wrEn   = psel && penable && pwrite && pready;
  wire         mapped = paddr[1:0] == 2'b00 && paddr <= `OFF_STATUS;
  wire  [15:0] assignWord = {assignHi_q, assignLo_q};  // R12
  wire  [15:0] seedWord16 = {seedHi_q, seedLo_q};  // R12
  wire         wrAssignLo = wrEn && paddr == `OFF_ASSIGN_LO;
  wire         wrAssignHi = wrEn && paddr == `OFF_ASSIGN_HI;
  wire         wrSeedLo   = wrEn && paddr == `OFF_SEED_LO;
  wire         wrSeedHi   = wrEn && paddr == `OFF_SEED_HI;
  wire         wrCarrier  = wrEn && paddr == `OFF_CARRIER;
  wire  [1:0]  wrCfg      = {wrEn && paddr == `OFF_ENC1_CFG, wrEn && paddr == `OFF_ENC0_CFG};
  wire  [1:0]  wrTe       = {wrEn && paddr == `OFF_ENC1_TE, wrEn && paddr == `OFF_ENC0_TE};
  wire  [1:0]  wrCnt      = {wrEn && paddr == `OFF_ENC1_CNT, wrEn && paddr == `OFF_ENC0_CNT};

  // low byte at the lower address, high byte after it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      assignLo_q <= 8'h00;
      assignHi_q <= 8'h00;
      seedLo_q   <= 8'h00;
      seedHi_q   <= 8'h00;
    end else begin
      if (wrAssignLo) assignLo_q <= pwdata[7:0];  // R12
      if (wrAssignHi) assignHi_q <= pwdata[7:0];  // R12
      if (wrSeedLo)   seedLo_q   <= pwdata[7:0];  // R12
      if (wrSeedHi)   seedHi_q   <= pwdata[7:0];  // R12
    end
  end

  // one carrier word serves both encoders
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      carrier_q <= 24'h000000;
    else if (wrCarrier)
      carrier_q <= pwdata[23:0];  // R01
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        encCfg_q[i] <= 22'h000000;
        teCyc_q[i]  <= `TE_CYC_RST;
        cntCfg_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrCfg[i]) encCfg_q[i] <= pwdata[21:0];
        if (wrTe[i])  teCyc_q[i]  <= pwdata[15:0];
        if (wrCnt[i]) cntCfg_q[i] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  word_state_t state_q;
  logic        enc_q, seed_q, held_q;
  // set when a held pattern ran out of words, cleared by release
  logic        spent_q;
  logic [3:0]  func_q;
  logic [7:0]  words_q;
  logic [31:0] tick_q;
  logic [15:0] teCnt_q;

  // R08 pattern index; R09 bit zero never requests
  wire  [3:0]  pattern = buttons;
  wire         request = pattern != 4'h0;
  wire         reqEnc  = assignWord[pattern];  // R10
  wire         reqSeed = seedWord16[pattern];  // R11
  wire  [7:0]  minCnt  = cntCfg_q[enc_q][7:0];
  wire  [7:0]  maxCnt  = cntCfg_q[enc_q][15:8];
  wire  [21:0] cfg     = encCfg_q[enc_q];
  wire         pwm     = cfg[`CFG_PWM_BIT];
  wire         teTick  = teCnt_q >= teCyc_q[enc_q] - 16'h0001;
  // guard runs in clock cycles, so every word starts on a fresh time element
  wire         teRestart = state_q == ST_IDLE || state_q == ST_GUARD || teTick;

  function automatic logic [31:0] dataTe(input logic adv, input logic isPwm);
    logic [31:0] total;
    total = adv ? (isPwm ? `TE_ADV_PWM : `TE_ADV_MAN)
                : (isPwm ? `TE_CLA_PWM : `TE_CLA_MAN);  // R17 R18 R16
    dataTe = total - `PRE_TE - `HDR_TE;
  endfunction : dataTe

  wire [31:0] guardCyc = enc_q ? 32'(FIX_ADV_CYC) : 32'(FIX_CLA_CYC);  // R17 R18
  wire [7:0]  nextWords = words_q + 8'h01;
  // R14 R15 R21: decide at word end only, never mid-word (R13)
  wire        another = (nextWords < maxCnt || maxCnt == 8'h00)
                        && (held_q || nextWords < minCnt);
  // R19 blank pattern
  wire        radiate = !cfg[`CFG_BLANK_BIT]
                        || (cfg[`CFG_BLANK4_BIT] ? words_q[1:0] == 2'b00 : !words_q[0]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      enc_q   <= 1'b0;
      seed_q  <= 1'b0;
      held_q  <= 1'b0;
      spent_q <= 1'b0;
      func_q  <= 4'h0;
      words_q <= 8'h00;
      tick_q  <= 32'h0;
      teCnt_q <= 16'h0000;
    end else begin
      teCnt_q <= teRestart ? 16'h0000 : teCnt_q + 16'h0001;
      if (state_q != ST_IDLE && !request)
        held_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          words_q <= 8'h00;
          tick_q  <= 32'h0;
          // a held pattern that hit its maximum must be released first
          if (!request)
            spent_q <= 1'b0;
          if (request && !spent_q) begin  // R21
            enc_q   <= reqEnc;
            seed_q  <= reqSeed;
            func_q  <= pattern;
            held_q  <= 1'b1;
            state_q <= ST_PREAMBLE;
          end
        end
        // R20 preamble, header, data, guard
        ST_PREAMBLE: if (teTick) begin
          tick_q <= (tick_q == `PRE_TE - 1) ? 32'h0 : tick_q + 32'h1;
          if (tick_q == `PRE_TE - 1)
            state_q <= ST_HEADER;
        end
        ST_HEADER: if (teTick) begin
          tick_q <= (tick_q == `HDR_TE - 1) ? 32'h0 : tick_q + 32'h1;
          if (tick_q == `HDR_TE - 1)
            state_q <= ST_DATA;
        end
        ST_DATA: if (teTick) begin
          tick_q <= (tick_q == dataTe(enc_q, pwm) - 1) ? 32'h0 : tick_q + 32'h1;
          if (tick_q == dataTe(enc_q, pwm) - 1)
            state_q <= ST_GUARD;
        end
        ST_GUARD: begin
          tick_q <= tick_q + 32'h1;
          if (tick_q >= guardCyc - 1) begin
            tick_q  <= 32'h0;
            words_q <= nextWords;
            state_q <= another ? ST_PREAMBLE : ST_IDLE;  // R13 R14 R15 R21
            spent_q <= !another && request;  // R21
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // indicator
  // ----------------------------------------
  logic [31:0] ledCnt_q;
  wire  [31:0] ledOn = lowBattery ? 32'(LED_LOWBAT) : 32'(LED_NORM);  // R07

  // ----------------------------------------
  // outputs and apb
  // ----------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    case (paddr)
      `OFF_ASSIGN_LO: rdMux = {24'h0, assignLo_q};
      `OFF_ASSIGN_HI: rdMux = {24'h0, assignHi_q};
      `OFF_SEED_LO:   rdMux = {24'h0, seedLo_q};
      `OFF_SEED_HI:   rdMux = {24'h0, seedHi_q};
      `OFF_CARRIER:   rdMux = {8'h0, carrier_q};
      `OFF_ENC0_CFG:  rdMux = {10'h0, encCfg_q[0]};
      `OFF_ENC1_CFG:  rdMux = {10'h0, encCfg_q[1]};
      `OFF_ENC0_TE:   rdMux = {16'h0, teCyc_q[0]};
      `OFF_ENC1_TE:   rdMux = {16'h0, teCyc_q[1]};
      `OFF_ENC0_CNT:  rdMux = {16'h0, cntCfg_q[0]};
      `OFF_ENC1_CNT:  rdMux = {16'h0, cntCfg_q[1]};
      `OFF_STATUS:    rdMux = {20'h0, words_q, 1'b0, state_q};
      default:        rdMux = 32'h0;
    endcase
  end

  // ----------------------------------------
  // output next values
  // ----------------------------------------
  // idle shares the guard code: the carrier is dark in both
  function automatic logic [1:0] phaseCode(input word_state_t st);
    case (st)
      ST_PREAMBLE: phaseCode = 2'd0;
      ST_HEADER:   phaseCode = 2'd1;
      ST_DATA:     phaseCode = 2'd2;
      default:     phaseCode = 2'd3;
    endcase
  endfunction : phaseCode

  wire         txOn      = state_q != ST_IDLE;
  wire         access    = psel && penable && !pready;
  wire         fskOn     = cfg[`CFG_FSK_BIT];
  wire  [15:0] devNext   = fskOn ? cfg[`CFG_DEV_LSB +: `CFG_DEV_W] : 16'h0000;  // R02
  wire  [1:0]  phaseNext = phaseCode(state_q);
  wire         ledWrap   = !txOn || ledCnt_q >= 32'(LED_PERIOD) - 32'h1;
  wire  [31:0] ledNext   = ledWrap ? 32'h0 : ledCnt_q + 32'h1;
  rf_setting_t rfNext;

  assign rfNext.deviation = devNext;  // R01 R02
  assign rfNext.fskMode   = fskOn;
  assign rfNext.highBand  = cfg[`CFG_BAND_BIT];  // R03
  assign rfNext.highPower = cfg[`CFG_PWR_BIT];  // R06

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // one wait state: ready in second access cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      prdata  <= rdMux;
      pslverr <= access && !mapped;
    end
  end

  // ----------------------------------------
  // transmitter status
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txActive     <= 1'b0;
      carrierOn    <= 1'b0;
      encoderSel   <= 1'b0;
      seedWord     <= 1'b0;
      functionCode <= 4'h0;
      wordPhase    <= 2'b00;
    end else begin
      txActive     <= txOn;
      carrierOn    <= txOn && state_q != ST_GUARD && radiate;  // R19
      encoderSel   <= enc_q;  // R10
      seedWord     <= seed_q;  // R11
      functionCode <= seed_q ? 4'hf : func_q;
      wordPhase    <= phaseNext;  // R20
    end
  end

  // ----------------------------------------
  // synthesizer settings
  // ----------------------------------------
  // settings follow the active encoder, so they only matter while it sends
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      carrier_frequency_word <= 24'h000000;
      rfSetting              <= '0;
    end else begin
      carrier_frequency_word <= carrier_q;  // R01
      rfSetting              <= rfNext;  // R01 R02 R03 R06
    end
  end

  // ----------------------------------------
  // indicator drive
  // ----------------------------------------
  // blink restarts with each transmission so the first flash is full length
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ledCnt_q <= 32'h0;
      ledOut_n <= 1'b1;
    end else begin
      ledCnt_q <= ledNext;
      ledOut_n <= !(txOn && ledCnt_q < ledOn);  // R07
    end
  end
endmodule : dual_encoder_tx_sequencing

// ===== tx_seq_defs.svh
// Behaviour
// R01: one shared carrier word, per-encoder deviation
// R02: deviation used only under FSK
// R03: per-encoder band bit, 0 low, 1 high
// R04: software computes words from reference frequency
// R05: software keeps words within documented bounds
// R06: per-encoder output power level select
// R07: active-low indicator blinks, low-battery duty differs
// R08: button pattern indexes both configuration words
// R09: all-released pattern never starts transmission
// R10: assignment bit picks classic or advanced encoder
// R11: seed bit picks normal or seed word
// R12: words stored low byte then high byte
// R13: started code word always completes
// R14: after release, send up to minimum count
// R15: transmission bounded by min and max counts
// R16: bit is 2 or 3 time elements
// R17: classic word 187/201 TE plus 23.979 ms
// R18: advanced word 437/629 TE plus 46.527 ms
// R19: blanking radiates every second or fourth word
// R20: word is preamble, header, data, then guard
// R21: max count reached stops after current word
`ifndef TX_SEQ_DEFS_SVH
`define TX_SEQ_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_ASSIGN_LO   12'h000
`define OFF_ASSIGN_HI   12'h004
`define OFF_SEED_LO     12'h008
`define OFF_SEED_HI     12'h00c
`define OFF_CARRIER     12'h010
`define OFF_ENC0_CFG    12'h014
`define OFF_ENC1_CFG    12'h018
`define OFF_ENC0_TE     12'h01c
`define OFF_ENC1_TE     12'h020
`define OFF_ENC0_CNT    12'h024
`define OFF_ENC1_CNT    12'h028
`define OFF_STATUS      12'h02c

// ----------------------------------------
// encoder config fields
// ----------------------------------------
`define CFG_DEV_LSB     0
`define CFG_DEV_W       16
`define CFG_FSK_BIT     16
`define CFG_BAND_BIT    17
`define CFG_PWR_BIT     18
`define CFG_PWM_BIT     19
`define CFG_BLANK_BIT   20
`define CFG_BLANK4_BIT  21

// ----------------------------------------
// code word timing
// ----------------------------------------
`define CLK_HZ          25000000
`define TE_CLA_MAN      187
`define TE_CLA_PWM      201
`define TE_ADV_MAN      437
`define TE_ADV_PWM      629
`define FIX_CLA_NS      23979000
`define FIX_ADV_NS      46527000
`define FIX_CLA_CYC     ((`FIX_CLA_NS / 40))
`define FIX_ADV_CYC     ((`FIX_ADV_NS / 40))
`define PRE_TE          12
`define HDR_TE          10
`define LED_PERIOD_CYC  2500000
`define LED_ON_NORM     1250000
`define LED_ON_LOWBAT   250000
`define TE_CYC_RST      16'h2710

`endif

// ===== tx_seq_pkg.sv
package tx_seq_pkg;
  typedef struct packed {
    logic [15:0] deviation;
    logic        fskMode;
    logic        highBand;
    logic        highPower;
  } rf_setting_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREAMBLE,
    ST_HEADER,
    ST_DATA,
    ST_GUARD
  } word_state_t;
endpackage : tx_seq_pkg

// ===== tx_seq_properties.sv
`timescale 1ns/10ps
module tx_seq_properties (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst,
  // watched ports
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    txActive,
  input wire logic                    carrierOn,
  input wire logic                    encoderSel,
  input wire logic                    seedWord,
  input wire logic [3:0]              functionCode,
  input wire logic [1:0]              wordPhase,
  input wire tx_seq_pkg::rf_setting_t rfSetting,
  input wire logic                    ledOut_n
);
  import tx_seq_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  a_error_paired: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fsk_deviation: assert property (!rfSetting.fskMode |-> rfSetting.deviation == 16'h0)
    else $error("deviation under on-off keying");
  a_seed_code: assert property (txActive && seedWord |-> functionCode == 4'hf)
    else $error("seed word code wrong");
  a_idle_ignored: assert property (txActive |-> functionCode != 4'h0)
    else $error("idle pattern transmitted");
  a_guard_dark: assert property (carrierOn |-> wordPhase != 2'd3)
    else $error("carrier on in guard");
  a_phase_order: assert property (
    txActive && $past(txActive) && $changed(wordPhase) |-> wordPhase == $past(wordPhase) + 2'd1)
    else $error("word phase out of order");
  a_word_whole: assert property (
    txActive && wordPhase != 2'd3 && $past(wordPhase) != 2'd3
    |-> $stable(encoderSel) && $stable(functionCode))
    else $error("word changed mid-flight");
  a_led_quiet: assert property (!txActive && !$past(txActive) |-> ledOut_n)
    else $error("indicator lit while idle");
endmodule : tx_seq_properties
bind dual_encoder_tx_sequencing tx_seq_properties tx_seq_properties_i (.clk_sys, .rst, .psel,
  .penable, .pready, .pslverr, .txActive, .carrierOn, .encoderSel, .seedWord, .functionCode,
  .wordPhase, .rfSetting, .ledOut_n);

// ===== rf_receiver_model.sv
`timescale 1ns/10ps
module rf_receiver_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // air side
  input  wire logic       clr,
  input  wire logic       carrierOn,
  input  wire logic [1:0] wordPhase,
  // decoded counts
  output logic [7:0]      words,
  output logic [7:0]      heard,
  output logic [15:0]     period
);
  logic [1:0]  phase_q;
  logic        seen_q;
  logic [15:0] cnt_q;
  // word closes on entry to guard, so period spans whole words
  always @(posedge clk_sys) begin
    phase_q <= wordPhase;
    cnt_q <= cnt_q + 16'h1;
    if (carrierOn) seen_q <= 1'b1;
    if (wordPhase == 2'd3 && phase_q == 2'd2) begin
      words <= words + 8'h1;
      heard <= heard + {7'h0, seen_q};
      if (words != 8'h0) period <= cnt_q + 16'h1;
      cnt_q <= 16'h0;
      seen_q <= 1'b0;
    end
    if (rst || clr) begin
      {words, heard, period, cnt_q} <= '0;
      seen_q <= 1'b0;
    end
  end
endmodule : rf_receiver_model

// ===== dual_encoder_tx_sequencing_tb.sv
`timescale 1ns/10ps
`include "tx_seq_defs.svh"
module dual_encoder_tx_sequencing_tb;
  import tx_seq_pkg::*;
  localparam int TE  = 2;
  localparam int FIX = 20;
  logic clk_sys = 1'b0, rst = 1'b1, clr = 1'b0, txPrev = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lowBattery = 1'b0;
  logic pready, pslverr, txActive, carrierOn, encoderSel, seedWord, ledOut_n;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  buttons = 4'h0, functionCode;
  logic [1:0]  wordPhase;
  logic [23:0] carrier_frequency_word, cw;
  logic [15:0] period, asg, sel, dev;
  logic [7:0]  words, heard;
  logic [63:0] expQ[$];
  rf_setting_t rfSetting;
  int err_count = 0, comparisons = 0, cycles = 0;
  dual_encoder_tx_sequencing #(.FIX_CLA_CYC(FIX), .FIX_ADV_CYC(FIX), .LED_PERIOD(20),
    .LED_NORM(10), .LED_LOWBAT(2)) dual_encoder_tx_sequencing_i (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .buttons, .lowBattery,
    .txActive, .carrierOn, .encoderSel, .seedWord, .functionCode, .wordPhase,
    .carrier_frequency_word, .rfSetting, .ledOut_n);
  rf_receiver_model rf_receiver_model_i (.clk_sys, .rst, .clr, .carrierOn, .wordPhase,
    .words, .heard, .period);
  initial forever #20 clk_sys = ~clk_sys;
  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [63:0] got);
    logic [63:0] exp;
    exp = ~got;
    if (expQ.size() > 0) exp = expQ.pop_front();
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  always @(posedge clk_sys) begin
    txPrev <= txActive;
    cycles <= cycles + 1;
    if (psel && penable && pready && !pwrite) check({31'h0, pslverr, prdata});
    if (txActive && !txPrev)
      check({15'h0, carrier_frequency_word, encoderSel, seedWord, functionCode, rfSetting});
    if (!txActive && txPrev) check({32'h0, words, heard, period});
    if (cycles == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [63:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic press(input logic [3:0] b, input logic hold, input logic [63:0] s, e);
    expQ.push_back(s);
    expQ.push_back(e);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    buttons <= b;
    repeat (4) @(posedge clk_sys);
    if (!hold) buttons <= 4'h0;
    while (txActive !== 1'b0) @(posedge clk_sys);
    buttons <= 4'h0;
    repeat (2) @(posedge clk_sys);
    $display("test done: pattern %h", b);
  endtask : press
  initial begin
    asg = 16'($urandom(32'h1720eea4));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`OFF_ENC0_TE, 64'd10000);
    rd(12'h030, 64'h1_0000_0000);
    asg = 16'($urandom);
    sel = 16'($urandom);
    asg[2:1] = 2'b10;
    sel[2:1] = 2'b10;
    dev = 16'(10 + $urandom % 100);
    cw = 24'h040000 + {8'h0, dev};
    apb(1'b1, `OFF_ASSIGN_LO, {24'h0, asg[7:0]});
    apb(1'b1, `OFF_ASSIGN_HI, {24'h0, asg[15:8]});
    apb(1'b1, `OFF_SEED_LO, {24'h0, sel[7:0]});
    apb(1'b1, `OFF_SEED_HI, {24'h0, sel[15:8]});
    rd(`OFF_ASSIGN_HI, {56'h0, asg[15:8]});
    rd(`OFF_SEED_LO, {56'h0, sel[7:0]});
    apb(1'b1, `OFF_CARRIER, {8'h0, cw});
    apb(1'b1, `OFF_ENC0_CFG, {13'h0, 3'b101, dev});
    apb(1'b1, `OFF_ENC1_CFG, {11'h0, 5'b11010, dev});
    apb(1'b1, `OFF_ENC0_TE, 32'h2);
    apb(1'b1, `OFF_ENC1_TE, 32'h2);
    apb(1'b1, `OFF_ENC0_CNT, 32'h0302);
    apb(1'b1, `OFF_ENC1_CNT, 32'h0302);
    lowBattery <= asg[15];
    press(4'h1, 1'b0, {15'h0, cw, 6'b000001, dev, 3'b101},
      {32'h0, 8'd2, 8'd2, 16'(187 * TE + FIX)});
    lowBattery <= ~asg[15];
    press(4'h2, 1'b1, {15'h0, cw, 6'b111111, 16'h0, 3'b010},
      {32'h0, 8'd3, 8'd2, 16'(629 * TE + FIX)});
    apb(1'b1, `OFF_ENC1_CFG, {10'h0, 6'b110011, dev});
    apb(1'b1, `OFF_ENC1_CNT, 32'h0005);
    press(4'h2, 1'b0, {15'h0, cw, 6'b111111, dev, 3'b110},
      {32'h0, 8'd5, 8'd2, 16'(437 * TE + FIX)});
    print_verdict;
  end
endmodule : dual_encoder_tx_sequencing_tb
